// *** host_local_bus_page_window_bench.sv ***
// Purpose: self-checking bench of host end facing device end
// Assumes: straps low at first; a mid-run reset raises them
// Notes:   bench answers the internal bus with one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module host_local_bus_page_window_bench;
  logic        sys_clk, rst_b, cmd_valid, cmd_ready, cmd_write, cmd_config, rsp_valid, rsp_ready;
  logic [1:0]  cmd_page, cmd_be_n;
  logic [20:0] cmd_addr;
  logic [15:0] cmd_wdata, rsp_data;
  logic        ibus_req, ibus_wr, ibus_ack, port_active, cap_wr;
  logic [2:0]  straps;
  logic [3:0]  ibus_be, cap_be;
  logic [31:0] ibus_addr, ibus_wdata, ibus_rdata, cap_addr, cap_wdata;
  int          errors, checks, ibus_n;
  hpu_if pins_if ();
  assign pins_if.ready_pull_level = straps[2];
  hpu_dev u_hpu_dev (.SYS_CLK(sys_clk), .RST_B(rst_b), .PORT_SELECT_STRAP(straps[0]),
    .STROBE_MODE_STRAP(straps[1]), .READY_POLARITY_STRAP(straps[2]), .PINS(pins_if.dev),
    .IBUS_REQ(ibus_req), .IBUS_WR(ibus_wr), .IBUS_ADDR(ibus_addr), .IBUS_BE(ibus_be),
    .IBUS_WDATA(ibus_wdata), .IBUS_ACK(ibus_ack), .IBUS_RDATA(ibus_rdata),
    .PORT_ACTIVE(port_active));
  hpu_host u_hpu_host (.SYS_CLK(sys_clk), .RST_B(rst_b), .STROBE_MODE(straps[1]),
    .READY_POL(straps[2]), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
    .CMD_CONFIG(cmd_config), .CMD_PAGE(cmd_page), .CMD_ADDR(cmd_addr), .CMD_BE_N(cmd_be_n),
    .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready),
    .RSP_DATA(rsp_data), .PINS(pins_if.host));
  hpu_chk u_hpu_chk (.SYS_CLK(sys_clk), .RST_B(rst_b), .host_addr_in(pins_if.host_addr_in),
    .host_write_strobe_n(pins_if.host_write_strobe_n),
    .host_read_strobe_n(pins_if.host_read_strobe_n),
    .memory_window_cs_n(pins_if.memory_window_cs_n),
    .page_config_cs_n(pins_if.page_config_cs_n), .dev_data_oe_n(pins_if.dev_data_oe_n),
    .host_ready_out(pins_if.host_ready_out), .host_ready_oe_n(pins_if.host_ready_oe_n),
    .ready_pull_level(pins_if.ready_pull_level));
  // ****************************************
  // clock and internal bus responder
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    #1;
    if (ibus_ack)
      ibus_ack = 1'b0;
    else if (ibus_req === 1'b1)
    begin
      {cap_addr, cap_wr, cap_be, cap_wdata} = {ibus_addr, ibus_wr, ibus_be, ibus_wdata};
      ibus_rdata = {ibus_addr[15:0] ^ 16'h5a5a, ibus_addr[15:0]};
      ibus_ack = 1'b1;
      ibus_n++;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic met(input int sel, input int want);
    return sel == 0 ? cmd_ready === 1'b1 : sel == 1 ? rsp_valid === 1'b1 : ibus_n == want;
  endfunction : met
  task automatic wait_on(input int sel, input int want);
    int i;
    for (i = 0; i < 400 && !met(sel, want); i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (!met(sel, want))
    begin
      errors++;
      $display("Error at %0t: wait timed out", $time);
      stop_test();
    end
  endtask : wait_on
  task automatic acc(input logic w, input logic c, input logic [1:0] pg, input logic [20:0] a,
                     input logic [1:0] be, input logic [15:0] d, output logic [15:0] q);
    {cmd_write, cmd_config, cmd_page, cmd_addr, cmd_be_n, cmd_wdata} = {w, c, pg, a, be, d};
    cmd_valid = 1'b1;
    wait_on(0, 0);
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    q = 16'h0;
    if (!w)
    begin
      wait_on(1, 0);
      q = rsp_data;
      rsp_ready = 1'b1;
      @(posedge sys_clk);
      #1 rsp_ready = 1'b0;
    end
    wait_on(0, 0);
  endtask : acc
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_cfg_reset();
    logic [15:0] q;
    logic [15:0] bh [4];
    bh = '{16'h1010, 16'h1000, 16'h3000, 16'h4000};
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b0, 1'b1, 2'h0, 21'(p * 16 + 6), 2'h0, 16'h0, q);
      check(q, bh[p]);
    end
    acc(1'b0, 1'b1, 2'h0, 21'h000030, 2'h0, 16'h0, q);
    check(q, 16'h0800);
    check(ibus_n, 0);
  endtask : t_cfg_reset
  task automatic t_map_read();
    logic [15:0] q;
    logic [31:0] ea [4];
    ea = '{32'h1010fffe, 32'h100ffffe, 32'h301ffffe, 32'h400027fe};
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b0, 1'b0, 2'(p), 21'h1ffffe, 2'h0, 16'h0, q);
      check(ibus_n, p + 1);
      check(cap_addr, ea[p]);
      check(q, ea[p][15:0] ^ 16'h5a5a);
    end
  endtask : t_map_read
  task automatic t_size_edge();
    logic [15:0] q;
    logic [15:0] ex [3];
    ex = '{16'hff00, 16'h003f, 16'hff00};
    for (int r = 0; r < 3; r++)
    begin
      acc(1'b1, 1'b1, 2'h0, 21'(48 + r * 2), 2'h0, 16'hffff, q);
      acc(1'b0, 1'b1, 2'h0, 21'(48 + r * 2), 2'h0, 16'h0, q);
      check(q, ex[r]);
    end
    acc(1'b0, 1'b0, 2'h3, 21'h1ffffe, 2'h0, 16'h0, q);
    check(cap_addr, 32'h401ffffe);
    acc(1'b1, 1'b1, 2'h0, 21'h000030, 2'h0, 16'h00ff, q);
    acc(1'b1, 1'b1, 2'h0, 21'h000032, 2'h0, 16'h0000, q);
    acc(1'b0, 1'b0, 2'h3, 21'h001234, 2'h0, 16'h0, q);
    check(cap_addr, 32'h4000ff34);
  endtask : t_size_edge
  task automatic t_map_write();
    logic [15:0] q;
    int n;
    n = ibus_n;
    acc(1'b1, 1'b0, 2'h2, 21'h000101, 2'b01, 16'hab00, q);
    wait_on(2, n + 1);
    check({cap_wr, cap_be, cap_addr}, {1'b1, 4'h2, 32'h30000101});
    check(cap_wdata, 32'hab00ab00);
  endtask : t_map_write
  task automatic t_pair32();
    logic [15:0] q;
    int n;
    acc(1'b1, 1'b1, 2'h0, 21'h000018, 2'h0, 16'h0001, q);
    n = ibus_n;
    acc(1'b1, 1'b0, 2'h1, 21'h000010, 2'h0, 16'h1111, q);
    check(ibus_n, n);
    acc(1'b1, 1'b0, 2'h1, 21'h000012, 2'h0, 16'h2222, q);
    wait_on(2, n + 1);
    check({cap_wr, cap_be, cap_addr}, {1'b1, 4'hf, 32'h10000010});
    check(cap_wdata, 32'h22221111);
    acc(1'b0, 1'b0, 2'h1, 21'h000010, 2'h0, 16'h0, q);
    check(q, 16'h0010);
    acc(1'b0, 1'b0, 2'h1, 21'h000012, 2'h0, 16'h0, q);
    check(q, 16'h5a4a);
    check(ibus_n, n + 2);
  endtask : t_pair32
  task automatic t_straps();
    logic [15:0] q;
    rst_b = 1'b0;
    straps = 3'b111;
    repeat (4) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(port_active, 32'h0);
    straps[0] = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check(port_active, 32'h1);
    acc(1'b0, 1'b1, 2'h0, 21'h000006, 2'h0, 16'h0, q);
    check(q, 16'h1010);
    acc(1'b1, 1'b0, 2'h2, 21'h000004, 2'h0, 16'h1234, q);
    check({cap_wr, cap_be, cap_addr}, {1'b1, 4'h3, 32'h30000004});
    check(cap_wdata, 32'h12341234);
    acc(1'b0, 1'b0, 2'h1, 21'h000102, 2'h0, 16'h0, q);
    check(q, 16'h5b58);
  endtask : t_straps
  initial
  begin
    {rst_b, cmd_valid, cmd_write, cmd_config, cmd_page, cmd_addr} = '0;
    {cmd_be_n, cmd_wdata, rsp_ready, ibus_ack, ibus_rdata, straps} = '0;
    {errors, checks, ibus_n} = '0;
    repeat (4) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(port_active, 32'h1);
    t_cfg_reset();
    t_map_read();
    t_size_edge();
    t_map_write();
    t_pair32();
    t_straps();
    stop_test();
  end
endmodule : host_local_bus_page_window_bench
`default_nettype wire

// *** hpu_buf.sv ***
// Purpose: small FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 2
// Notes:   out_data is the head entry
`timescale 1ns/1ps
`default_nettype none
module hpu_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } hpu_buf_s;

  hpu_buf_s s_ff;
  hpu_buf_s nxt_s;
  logic     full;
  logic     empty;

  assign empty     = (s_ff.wp == s_ff.rp);
  assign full      = (s_ff.wp[AW] != s_ff.rp[AW]) && (s_ff.wp[AW-1:0] == s_ff.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = s_ff.mem[s_ff.rp[AW-1:0]];

  always_comb
  begin
    nxt_s = s_ff;
    if (in_valid && !full)
    begin
      nxt_s.mem[s_ff.wp[AW-1:0]] = in_data;
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (out_ready && !empty)
      nxt_s.rp = s_ff.rp + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
endmodule : hpu_buf
`default_nettype wire

// *** hpu_chk_sva.sv ***
// Purpose: pin-level checks between host end and device end
// Assumes: one clock; ready_pull_level equals the active ready level
// Notes:   ready counts as active only while driven to that level
`timescale 1ns/1ps
`default_nettype none
module hpu_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST_B,
  input wire logic [20:0] host_addr_in,
  input wire logic        host_write_strobe_n,
  input wire logic        host_read_strobe_n,
  input wire logic        memory_window_cs_n,
  input wire logic        page_config_cs_n,
  input wire logic        dev_data_oe_n,
  input wire logic        host_ready_out,
  input wire logic        host_ready_oe_n,
  input wire logic        ready_pull_level
);
  // ****************************************
  // helper state
  // ****************************************
  logic       rdy_act;
  logic       any_cs;
  logic [3:0] since_ff;
  logic [3:0] nxt_since;
  assign rdy_act   = !host_ready_oe_n && (host_ready_out == ready_pull_level);
  assign any_cs    = !memory_window_cs_n || !page_config_cs_n;
  assign nxt_since = rdy_act ? 4'h0 : since_ff + {3'h0, since_ff != 4'hf};
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      since_ff <= 4'hf;
    else
      since_ff <= nxt_since;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ****************************************
  // assertions
  // ****************************************
  rdy_pulse_len_a: assert property ($rose(rdy_act) |-> rdy_act [*5] ##1 host_ready_oe_n)
    else $error("ready pulse length wrong");
  rdy_first_a: assert property ($fell(host_ready_oe_n) |-> !rdy_act)
    else $error("ready not inactive first");
  rdy_slave_a: assert property ($fell(host_ready_oe_n) |-> any_cs)
    else $error("ready driven without access");
  rdy_idle_a: assert property ((!any_cs) [*8] |-> host_ready_oe_n)
    else $error("ready still driven when idle");
  dev_drive_rd_a: assert property (!dev_data_oe_n |-> host_write_strobe_n)
    else $error("data driven during write");
  data_on_rdy_a: assert property ($rose(rdy_act) && !host_read_strobe_n |-> !dev_data_oe_n)
    else $error("read data missing at ready");
  data_stands_a: assert property (!dev_data_oe_n && !host_read_strobe_n |=> !dev_data_oe_n)
    else $error("read data dropped early");
  host_hold_a: assert property ($rose(memory_window_cs_n) || $rose(page_config_cs_n)
    |-> since_ff < 4'h8)
    else $error("access released before ready");
  host_gap_a: assert property ($rose(memory_window_cs_n) |-> (!any_cs) [*4])
    else $error("gap after access too short");
  addr_hold_a: assert property (any_cs && $past(any_cs) |-> $stable(host_addr_in))
    else $error("address moved during access");
endmodule : hpu_chk
`default_nettype wire

// *** hpu_defs.svh ***
// Purpose: constants of the host port unit (page window bridge)
// Assumes: 250 MHz SYS_CLK
// Notes:   register numbers are 16-bit word indices (address bits 3:1) on the config chip select
`ifndef HPU_DEFS_SVH
`define HPU_DEFS_SVH

// ****************************************
// register map (config chip select)
// ****************************************
`define HPU_PAGE_SEL_HI   5
`define HPU_PAGE_SEL_LO   4
`define HPU_REG_SEL_HI    3
`define HPU_REG_SEL_LO    1
`define HPU_REG_SIZE_LO   3'h0
`define HPU_REG_SIZE_HI   3'h1
`define HPU_REG_BASE_LO   3'h2
`define HPU_REG_BASE_HI   3'h3
`define HPU_REG_WCTL      3'h4
`define HPU_WCTL_ORG32    0
`define HPU_SIZE_MASK     32'h003fff00
`define HPU_BASE_MASK     32'hffffff00
`define HPU_MIN_PAGE_BIT  8
`define HPU_MAX_PAGE_BIT  21

// ****************************************
// reset values
// ****************************************
`define HPU_P0_SIZE_LO    16'h0000
`define HPU_P0_SIZE_HI    16'h0001
`define HPU_P0_BASE_LO    16'h0000
`define HPU_P0_BASE_HI    16'h1010
`define HPU_P1_SIZE_LO    16'h0000
`define HPU_P1_SIZE_HI    16'h0010
`define HPU_P1_BASE_LO    16'h0000
`define HPU_P1_BASE_HI    16'h1000
`define HPU_P2_SIZE_LO    16'h0000
`define HPU_P2_SIZE_HI    16'h0020
`define HPU_P2_BASE_LO    16'h0000
`define HPU_P2_BASE_HI    16'h3000
`define HPU_P3_SIZE_LO    16'h0800
`define HPU_P3_SIZE_HI    16'h0000
`define HPU_P3_BASE_LO    16'h2000
`define HPU_P3_BASE_HI    16'h4000
`define HPU_WCTL_RST      16'h0000

// ****************************************
// timing
// ****************************************
`define HPU_CLK_NS        4
`define HPU_RDY_NS        20
`define HPU_GAP_CYC       4

`endif

// *** hpu_dev.sv ***
// Purpose: device end of the host port unit, page window bridge
// Assumes: straps steady around reset; internal bus ack is a pulse
// Notes:   internal request held until IBUS_ACK
`timescale 1ns/1ps
`default_nettype none
`include "hpu_defs.svh"
module hpu_dev
  import hpu_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        PORT_SELECT_STRAP,
  input  wire logic        STROBE_MODE_STRAP,
  input  wire logic        READY_POLARITY_STRAP,
  hpu_if.dev               PINS,
  output logic             IBUS_REQ,
  output logic             IBUS_WR,
  output logic [31:0]      IBUS_ADDR,
  output logic [3:0]       IBUS_BE,
  output logic [31:0]      IBUS_WDATA,
  input  wire logic        IBUS_ACK,
  input  wire logic [31:0] IBUS_RDATA,
  output logic             PORT_ACTIVE
);
  localparam int RDY_CYC = `HPU_RDY_NS / `HPU_CLK_NS;

  localparam logic [3:0][4:0][15:0] REG_RST = {
    {`HPU_WCTL_RST, `HPU_P3_BASE_HI, `HPU_P3_BASE_LO, `HPU_P3_SIZE_HI, `HPU_P3_SIZE_LO},
    {`HPU_WCTL_RST, `HPU_P2_BASE_HI, `HPU_P2_BASE_LO, `HPU_P2_SIZE_HI, `HPU_P2_SIZE_LO},
    {`HPU_WCTL_RST, `HPU_P1_BASE_HI, `HPU_P1_BASE_LO, `HPU_P1_SIZE_HI, `HPU_P1_SIZE_LO},
    {`HPU_WCTL_RST, `HPU_P0_BASE_HI, `HPU_P0_BASE_LO, `HPU_P0_SIZE_HI, `HPU_P0_SIZE_LO}
  };
  localparam hpu_dev_s DEV_RST = {REG_RST, {($bits(hpu_dev_s) - $bits(REG_RST)){1'b0}}};

  hpu_dev_s    s_ff;
  hpu_dev_s    nxt_s;
  hpu_pins_s   pin_raw;
  hpu_pins_s   p;
  logic        port_en;
  logic        req_seen;
  logic        acc;
  logic [1:0]  pg;
  logic [2:0]  ri;
  logic [31:0] rng;
  logic [31:0] base;
  logic [31:0] ia;
  logic        org32;
  logic [15:0] wmask;

  // ****************************************
  // window address
  // ****************************************
  function automatic logic [31:0] page_addr(input logic [31:0] r,
                                            input logic [31:0] b,
                                            input logic [20:0] a);
    logic [31:0] m;
    m = 32'h000000ff;
    for (int k = `HPU_MIN_PAGE_BIT; k <= `HPU_MAX_PAGE_BIT; k++)
      if (r[k])
        m = (32'h00000001 << k) - 32'h00000001;
    return (b & ~m) | ({11'h000, a} & m);
  endfunction : page_addr

  // ****************************************
  // pin sampling
  // ****************************************
  assign pin_raw = '{cs_m_n: PINS.memory_window_cs_n, cs_r_n: PINS.page_config_cs_n,
                     wr_n: PINS.host_write_strobe_n, rd_n: PINS.host_read_strobe_n,
                     be_n: PINS.host_byte_enable_n, seg: PINS.page_select_in,
                     addr: PINS.host_addr_in, data: PINS.host_data_io};
  assign p        = s_ff.ps2;
  assign port_en  = !s_ff.strap2[0] && (s_ff.boot == 2'h3);
  assign req_seen = (!p.cs_m_n || !p.cs_r_n) &&
                    (s_ff.strobe_mode || !p.rd_n || !p.wr_n);
  assign acc      = port_en && req_seen;

  assign pg    = p.cs_r_n ? p.seg : p.addr[`HPU_PAGE_SEL_HI:`HPU_PAGE_SEL_LO];
  assign ri    = p.addr[`HPU_REG_SEL_HI:`HPU_REG_SEL_LO];
  assign rng   = {s_ff.regs[pg][`HPU_REG_SIZE_HI], s_ff.regs[pg][`HPU_REG_SIZE_LO]};
  assign base  = {s_ff.regs[pg][`HPU_REG_BASE_HI], s_ff.regs[pg][`HPU_REG_BASE_LO]};
  assign ia    = page_addr(rng, base, p.addr);
  assign org32 = s_ff.regs[pg][`HPU_REG_WCTL][`HPU_WCTL_ORG32] && (p.be_n == 2'b00);

  always_comb
  begin
    wmask = 16'hffff;
    if (ri == `HPU_REG_SIZE_LO)
      wmask = 16'(`HPU_SIZE_MASK);
    else if (ri == `HPU_REG_SIZE_HI)
      wmask = 16'(`HPU_SIZE_MASK >> 16);
    else if (ri == `HPU_REG_BASE_LO)
      wmask = 16'(`HPU_BASE_MASK);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ps1 = pin_raw;
    nxt_s.ps2 = s_ff.ps1;
    nxt_s.strap1 = {READY_POLARITY_STRAP, STROBE_MODE_STRAP, PORT_SELECT_STRAP};
    nxt_s.strap2 = s_ff.strap1;
    if (s_ff.boot != 2'h3)
      nxt_s.boot = s_ff.boot + 2'h1;
    if (s_ff.boot == 2'h2)
    begin
      nxt_s.strobe_mode = s_ff.strap2[1];
      nxt_s.ready_pol   = s_ff.strap2[2];
    end
    case (s_ff.st)
      DEV_IDLE:
      begin
        nxt_s.data_oe = 1'b0;
        if (acc)
        begin
          nxt_s.st = DEV_BUSY;
          nxt_s.is_wr = !p.wr_n;
          nxt_s.lo_fetch = 1'b0;
          if (!p.cs_r_n)
          begin
            // page registers answer whatever the window is doing
            if (!p.wr_n && p.be_n == 2'b00 && ri <= `HPU_REG_WCTL)
              nxt_s.regs[pg][ri] = p.data & wmask;
            nxt_s.rdata = (ri <= `HPU_REG_WCTL) ? s_ff.regs[pg][ri] : 16'h0000;
          end
          else if (org32 && p.addr[1])
          begin
            if (!p.wr_n)
            begin
              nxt_s.ireq = 1'b1;
              nxt_s.iwr = 1'b1;
              nxt_s.iaddr = {ia[31:2], 2'b00};
              nxt_s.ibe = 4'hf;
              nxt_s.iwdata = {p.data, s_ff.hold_lo};
            end
            else
              nxt_s.rdata = s_ff.hi_buf;
          end
          else if (org32)
          begin
            if (!p.wr_n)
              nxt_s.hold_lo = p.data;
            else
            begin
              nxt_s.ireq = 1'b1;
              nxt_s.iwr = 1'b0;
              nxt_s.iaddr = {ia[31:2], 2'b00};
              nxt_s.ibe = 4'hf;
              nxt_s.lo_fetch = 1'b1;
            end
          end
          else
          begin
            nxt_s.ireq = 1'b1;
            nxt_s.iwr = !p.wr_n;
            nxt_s.iaddr = ia;
            nxt_s.ibe = {~p.be_n[1] & p.addr[1], ~p.be_n[0] & p.addr[1],
                         ~p.be_n[1] & ~p.addr[1], ~p.be_n[0] & ~p.addr[1]};
            nxt_s.iwdata = {p.data, p.data};
          end
        end
      end
      DEV_BUSY:
      begin
        if (!s_ff.ireq || IBUS_ACK)
        begin
          nxt_s.ireq = 1'b0;
          nxt_s.st = DEV_RDY;
          nxt_s.cnt = 4'(RDY_CYC - 1);
          nxt_s.data_oe = !s_ff.is_wr;
          if (s_ff.ireq && !s_ff.iwr)
          begin
            if (s_ff.lo_fetch)
            begin
              nxt_s.rdata = IBUS_RDATA[15:0];
              nxt_s.hi_buf = IBUS_RDATA[31:16];
            end
            else
              nxt_s.rdata = s_ff.iaddr[1] ? IBUS_RDATA[31:16] : IBUS_RDATA[15:0];
          end
        end
      end
      DEV_RDY:
      begin
        nxt_s.cnt = s_ff.cnt - 4'h1;
        if (s_ff.cnt == 4'h0)
          nxt_s.st = DEV_DONE;
      end
      DEV_DONE:
      begin
        if (!req_seen)
        begin
          nxt_s.st = DEV_IDLE;
          nxt_s.data_oe = 1'b0;
        end
      end
      default:
        nxt_s.st = DEV_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      s_ff <= DEV_RST;
    else
      s_ff <= nxt_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PINS.host_ready_oe_n = !(s_ff.st == DEV_BUSY || s_ff.st == DEV_RDY);
  assign PINS.host_ready_out  = (s_ff.st == DEV_RDY) ? s_ff.ready_pol : !s_ff.ready_pol;
  assign PINS.dev_data_out    = s_ff.rdata;
  assign PINS.dev_data_oe_n   = !s_ff.data_oe;
  assign IBUS_REQ    = s_ff.ireq;
  assign IBUS_WR     = s_ff.iwr;
  assign IBUS_ADDR   = s_ff.iaddr;
  assign IBUS_BE     = s_ff.ibe;
  assign IBUS_WDATA  = s_ff.iwdata;
  assign PORT_ACTIVE = port_en;
endmodule : hpu_dev
`default_nettype wire

// *** hpu_host.sv ***
// Purpose: host end, masters one access at a time on the pins
// Assumes: STROBE_MODE and READY_POL match the device straps
// Notes:   read data queue in a two-entry buffer
`timescale 1ns/1ps
`default_nettype none
`include "hpu_defs.svh"
module hpu_host
  import hpu_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        STROBE_MODE,
  input  wire logic        READY_POL,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic        CMD_WRITE,
  input  wire logic        CMD_CONFIG,
  input  wire logic [1:0]  CMD_PAGE,
  input  wire logic [20:0] CMD_ADDR,
  input  wire logic [1:0]  CMD_BE_N,
  input  wire logic [15:0] CMD_WDATA,
  output logic             RSP_VALID,
  input  wire logic        RSP_READY,
  output logic [15:0]      RSP_DATA,
  hpu_if.host              PINS
);
  localparam hpu_pins_s IDLE_PINS = '{cs_m_n: 1'b1, cs_r_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                                      be_n: 2'b11, seg: 2'b00, addr: 21'h000000,
                                      data: 16'h0000};

  hpu_hst_s s_ff;
  hpu_hst_s nxt_s;
  logic     buf_in_ready;

  assign CMD_READY = (s_ff.st == HST_IDLE) && buf_in_ready;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rs1 = PINS.host_ready_line;
    nxt_s.rs2 = s_ff.rs1;
    nxt_s.ds1 = PINS.host_data_io;
    nxt_s.ds2 = s_ff.ds1;
    nxt_s.push = 1'b0;
    case (s_ff.st)
      HST_IDLE:
      begin
        if (CMD_VALID && buf_in_ready)
        begin
          nxt_s.st = HST_SEEK;
          nxt_s.is_rd = !CMD_WRITE;
          nxt_s.oe_n = !CMD_WRITE;
          nxt_s.po.cs_r_n = !CMD_CONFIG;
          nxt_s.po.cs_m_n = CMD_CONFIG;
          nxt_s.po.wr_n = !CMD_WRITE;
          nxt_s.po.rd_n = STROBE_MODE || CMD_WRITE;
          nxt_s.po.be_n = CMD_CONFIG && CMD_WRITE ? 2'b00 : CMD_BE_N;
          nxt_s.po.seg = CMD_PAGE;
          nxt_s.po.addr = CMD_ADDR;
          nxt_s.po.data = CMD_WDATA;
        end
      end
      HST_SEEK:
        if (s_ff.rs2 != READY_POL)
          nxt_s.st = HST_WAIT;
      HST_WAIT:
      begin
        if (s_ff.rs2 == READY_POL)
        begin
          nxt_s.rdata = s_ff.ds2;
          nxt_s.push = s_ff.is_rd;
          nxt_s.po = IDLE_PINS;
          nxt_s.oe_n = 1'b1;
          nxt_s.cnt = 3'(`HPU_GAP_CYC - 1);
          nxt_s.st = HST_GAP;
        end
      end
      HST_GAP:
      begin
        nxt_s.cnt = s_ff.cnt - 3'h1;
        if (s_ff.cnt == 3'h0)
          nxt_s.st = HST_IDLE;
      end
      default:
        nxt_s.st = HST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s_ff <= '0;
      s_ff.po <= IDLE_PINS;
      s_ff.oe_n <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  hpu_buf #(
    .W     (16),
    .DEPTH (2)
  ) u_rsp_buf (
    .sys_clk   (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (s_ff.push),
    .in_ready  (buf_in_ready),
    .in_data   (s_ff.rdata),
    .out_valid (RSP_VALID),
    .out_ready (RSP_READY),
    .out_data  (RSP_DATA)
  );

  assign PINS.memory_window_cs_n  = s_ff.po.cs_m_n;
  assign PINS.page_config_cs_n    = s_ff.po.cs_r_n;
  assign PINS.host_write_strobe_n = s_ff.po.wr_n;
  assign PINS.host_read_strobe_n  = s_ff.po.rd_n;
  assign PINS.host_byte_enable_n  = s_ff.po.be_n;
  assign PINS.page_select_in      = s_ff.po.seg;
  assign PINS.host_addr_in        = s_ff.po.addr;
  assign PINS.host_data_out       = s_ff.po.data;
  assign PINS.host_data_oe_n      = s_ff.oe_n;
endmodule : hpu_host
`default_nettype wire

// *** hpu_if.sv ***
// Purpose: pins between host and host port unit
// Assumes: tb drives ready_pull_level (board resistor)
// Notes:   undriven data bus floats to all ones
`timescale 1ns/1ps
`default_nettype none
interface hpu_if;
  logic [20:0] host_addr_in;
  logic [1:0]  page_select_in;
  logic [1:0]  host_byte_enable_n;
  logic        host_write_strobe_n;
  logic        host_read_strobe_n;
  logic        memory_window_cs_n;
  logic        page_config_cs_n;
  logic [15:0] host_data_out;
  logic        host_data_oe_n;
  logic [15:0] dev_data_out;
  logic        dev_data_oe_n;
  logic        host_ready_out;
  logic        host_ready_oe_n;
  logic        ready_pull_level;
  logic [15:0] host_data_io;
  logic        host_ready_line;

  // ****************************************
  // wire resolution
  // ****************************************
  assign host_data_io = !dev_data_oe_n ? dev_data_out :
                        !host_data_oe_n ? host_data_out : 16'hffff;
  assign host_ready_line = !host_ready_oe_n ? host_ready_out : ready_pull_level;

  modport dev (
    input  host_addr_in, page_select_in, host_byte_enable_n, host_write_strobe_n,
    input  host_read_strobe_n, memory_window_cs_n, page_config_cs_n, host_data_io,
    output dev_data_out, dev_data_oe_n, host_ready_out, host_ready_oe_n
  );
  modport host (
    output host_addr_in, page_select_in, host_byte_enable_n, host_write_strobe_n,
    output host_read_strobe_n, memory_window_cs_n, page_config_cs_n,
    output host_data_out, host_data_oe_n,
    input  host_data_io, host_ready_line
  );
endinterface : hpu_if
`default_nettype wire

// *** hpu_pkg.sv ***
// Purpose: types of the host port unit
// Assumes: hpu_defs.svh constants
// Notes:   state structs hold all flops of hpu_dev, and of hpu_host outside its buffer
package hpu_pkg;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_BUSY = 2'b01,
    DEV_RDY  = 2'b10,
    DEV_DONE = 2'b11
  } hpu_dev_st_e;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SEEK = 2'b01,
    HST_WAIT = 2'b10,
    HST_GAP  = 2'b11
  } hpu_hst_st_e;

  typedef struct packed {
    logic        cs_m_n;
    logic        cs_r_n;
    logic        wr_n;
    logic        rd_n;
    logic [1:0]  be_n;
    logic [1:0]  seg;
    logic [20:0] addr;
    logic [15:0] data;
  } hpu_pins_s;

  typedef struct packed {
    logic [3:0][4:0][15:0] regs;
    hpu_dev_st_e           st;
    hpu_pins_s             ps1;
    hpu_pins_s             ps2;
    logic [2:0]            strap1;
    logic [2:0]            strap2;
    logic [1:0]            boot;
    logic                  strobe_mode;
    logic                  ready_pol;
    logic [3:0]            cnt;
    logic                  is_wr;
    logic                  lo_fetch;
    logic                  data_oe;
    logic [15:0]           hold_lo;
    logic [15:0]           hi_buf;
    logic [15:0]           rdata;
    logic                  ireq;
    logic                  iwr;
    logic [31:0]           iaddr;
    logic [3:0]            ibe;
    logic [31:0]           iwdata;
  } hpu_dev_s;

  typedef struct packed {
    hpu_hst_st_e st;
    logic [2:0]  cnt;
    logic        rs1;
    logic        rs2;
    logic [15:0] ds1;
    logic [15:0] ds2;
    hpu_pins_s   po;
    logic        oe_n;
    logic        is_rd;
    logic [15:0] rdata;
    logic        push;
  } hpu_hst_s;

endpackage : hpu_pkg
